//--- include/urxcg_defines.vh
// Purpose: Constants for the receive command byte generator
// Assumes: Single link clock from the transceiver side
// Notes:   Field positions and encodings of the receive command byte
`ifndef URXCG_DEFINES_VH
`define URXCG_DEFINES_VH

`define URXCG_LS_LSB      0
`define URXCG_VBUS_LSB    2
`define URXCG_EVT_LSB     4
`define URXCG_ID_BIT      6
`define URXCG_ALT_BIT     7

`define URXCG_VBUS_END    2'h0
`define URXCG_VBUS_MID    2'h1
`define URXCG_VBUS_SESS   2'h2
`define URXCG_VBUS_VALID  2'h3

`define URXCG_EVT_NONE    2'h0
`define URXCG_EVT_ACT     2'h1
`define URXCG_EVT_DISC    2'h2
`define URXCG_EVT_ERR     2'h3

`define URXCG_DATA_RESET  8'h00

`define URXCG_LS_MASK     8'h03
`define URXCG_CMP_MASK    8'h4C
`define URXCG_OTH_MASK    8'hB0

`endif

//--- core/urxcg_core.v
// Purpose: Builds the receive command byte and decides when it goes out on the data bus
// Assumes: All inputs synchronous to clk; bus turn-around handled by the DIR owner logic here
// Notes:   Register access and transmit paths live elsewhere; they hand in busy/stop status
//          A transmit that ends without STP keeps the hold set until STP arrives
`timescale 1ns/10ps
`default_nettype none
`include "urxcg_defines.vh"

module urxcg_core (
  input  wire       clk,                 // Link clock
  input  wire       reset,               // Synchronous, active high
  input  wire       sync_mode,           // High in synchronous mode
  input  wire       startup_done,        // Pulse: start-up DIR release done
  input  wire       mode_exit,           // Pulse: left low power/serial/carkit via STP
  input  wire       stp,                 // Link stop signal
  input  wire       link_busy,           // Link driving a command on the bus
  input  wire       tx_active,           // USB transmit in progress
  input  wire       rx_active,           // USB receive in progress
  input  wire       rx_error,            // Receive error seen
  input  wire       rx_nxt,              // Receiver has a data byte this cycle
  input  wire [7:0] rx_byte,             // Received data byte
  input  wire       host_disconnect_flag,// Host disconnect detected
  input  wire       dp_rx,               // DP single-ended receiver
  input  wire       dm_rx,               // DM single-ended receiver
  input  wire       session_end_flag,    // VBUS below session end
  input  wire       session_valid_flag,  // VBUS above session valid
  input  wire       vbus_valid_flag,     // VBUS above VBUS valid
  input  wire       id_pin,              // ID pin level
  input  wire       alt_int,             // Unmasked carkit interrupt latch set
  output reg        dir_q,               // PHY owns data bus
  output reg        nxt_q,               // Next byte strobe
  output reg  [7:0] data_out_q,          // Data bus drive value
  output reg        data_oe_q,           // Data bus output enable
  output reg        rxcmd_sent_q         // Pulse: a command byte was driven
);

  ////////////////////////////////////////////////////////////////////////////
  // Field encoding

  function [1:0] vbus_enc;
    input vv;
    input sv;
    input se;
    begin
      if (vv)
        vbus_enc = `URXCG_VBUS_VALID;
      else if (sv)
        vbus_enc = `URXCG_VBUS_SESS;
      else if (se)
        vbus_enc = `URXCG_VBUS_END;
      else
        vbus_enc = `URXCG_VBUS_MID;
    end
  endfunction

  // Receive activity outranks a disconnect report; the field holds only one event
  function [1:0] evt_enc;
    input act;
    input err;
    input disc;
    begin
      if (act)
        evt_enc = err ? `URXCG_EVT_ERR : `URXCG_EVT_ACT;
      else if (disc)
        evt_enc = `URXCG_EVT_DISC;
      else
        evt_enc = `URXCG_EVT_NONE;
    end
  endfunction

  // Field-wise compare shared by the change detectors
  function fld_diff;
    input [7:0] now_v;
    input [7:0] old_v;
    input [7:0] sel;
    begin
      fld_diff = |((now_v ^ old_v) & sel);
    end
  endfunction

  // Byte layout from the top: alt flag, ID, event, VBUS level, line state
  reg  [1:0] evt;
  reg  [7:0] cmd_byte;

  always @* begin
    evt      = evt_enc(rx_active, rx_error, host_disconnect_flag);
    cmd_byte = {alt_int,
                id_pin,
                evt,
                vbus_enc(vbus_valid_flag, session_valid_flag, session_end_flag),
                dm_rx, dp_rx};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change detection and pending request

  // last_q clears to zero, so a nonzero live state is reported once after reset
  reg  [7:0] last_q;
  reg        pend_q;
  reg        tx_hold_q;
  wire       ls_chg   = fld_diff(cmd_byte, last_q, `URXCG_LS_MASK);
  wire       cmp_chg  = fld_diff(cmd_byte, last_q, `URXCG_CMP_MASK);
  wire       oth_chg  = fld_diff(cmd_byte, last_q, `URXCG_OTH_MASK);
  wire       trig     = ls_chg
                     || cmp_chg
                     || oth_chg
                     || startup_done
                     || mode_exit;
  // An idle receive slot is an owned cycle that carries no data byte
  wire       rx_slot  = rx_active && dir_q && !rx_nxt;
  // The first transmit cycle is blocked before the hold flop has caught up
  wire       tx_block = tx_hold_q || (tx_active && !stp);
  // A refused request stays pending; an idle receive slot out of sync mode clears it without sending
  wire       can_send = sync_mode
                     && !link_busy
                     && !tx_block;
  wire       send_req = pend_q || trig || rx_active;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit hold: set by a transmit without STP, released by STP

  always @(posedge clk) begin
    if (reset) begin
      tx_hold_q <= 1'b0;
    end else if (tx_active && !stp) begin
      tx_hold_q <= 1'b1;
    end else if (stp) begin
      tx_hold_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus ownership: turn-around cycle after DIR rises, then drive

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_TURN = 2'h1;
  localparam [1:0] S_SEND = 2'h2;
  localparam [1:0] S_RX   = 2'h3;

  reg  [1:0] st_q;

  always @(posedge clk) begin
    if (reset) begin
      st_q         <= S_IDLE;
      dir_q        <= 1'b0;
      nxt_q        <= 1'b0;
      data_out_q   <= `URXCG_DATA_RESET;
      data_oe_q    <= 1'b0;
      rxcmd_sent_q <= 1'b0;
      pend_q       <= 1'b0;
      last_q       <= `URXCG_DATA_RESET;
    end else begin
      rxcmd_sent_q <= 1'b0;
      nxt_q        <= 1'b0;
      if (trig)
        pend_q <= 1'b1;                                   // Set wins over the send clear below
      last_q <= cmd_byte;
      case (st_q)
        S_IDLE: begin
          // Requests wait here while refused
          data_oe_q <= 1'b0;
          if (can_send && send_req) begin
            dir_q <= 1'b1;
            st_q  <= S_TURN;
          end
        end
        S_TURN: begin
          // Neither side drives the bus during the turn-around cycle
          st_q <= rx_active ? S_RX : S_SEND;
        end
        S_SEND: begin
          // With the mode gone, drive no byte and keep the request pending; DIR still stays high while rx_active
          if (sync_mode) begin
            data_out_q   <= cmd_byte;
            data_oe_q    <= 1'b1;
            rxcmd_sent_q <= 1'b1;
            if (!trig)
              pend_q <= 1'b0;
          end
          st_q <= rx_active ? S_RX : S_IDLE;
          if (!rx_active)
            dir_q <= 1'b0;
        end
        S_RX: begin
          // The bus stays ours for the whole packet; idle slots carry command bytes
          data_oe_q <= sync_mode;
          if (!rx_active) begin
            dir_q     <= 1'b0;
            data_oe_q <= 1'b0;
            st_q      <= S_IDLE;
          end else if (rx_nxt) begin
            nxt_q      <= 1'b1;
            data_out_q <= rx_byte;
          end else if (rx_slot) begin
            data_out_q   <= cmd_byte;
            rxcmd_sent_q <= sync_mode;
            if (!trig)
              pend_q <= 1'b0;
          end
        end
        default: begin
          st_q  <= S_IDLE;
          dir_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // urxcg_core
`default_nettype wire

//--- sim/urxcg_checker.sv
// Purpose: Timing checks on command byte output
// Assumes: Bench holds inputs calm around triggers
// Notes: Byte fields are judged by the bench
`timescale 1ns/10ps
`default_nettype none
module urxcg_checker (
  input wire logic clk,          // clock
  input wire logic reset,        // reset
  input wire logic sync_mode,    // mode
  input wire logic link_busy,    // link bus
  input wire logic tx_active,    // transmit
  input wire logic stp,          // stop
  input wire logic startup_done, // start
  input wire logic mode_exit,    // exit
  input wire logic dp_rx,        // line
  input wire logic dir_q,        // owner
  input wire logic nxt_q,        // strobe
  input wire logic data_oe_q,    // drive
  input wire logic rxcmd_sent_q  // byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire ok = sync_mode && !link_busy && !tx_active;
  // Free bus for three cycles; the answer may take one to six more
  sequence s_trig(e); e && !dir_q && ok ##1 ok [*2]; endsequence
  property p_oe; rxcmd_sent_q |-> data_oe_q && !nxt_q; endproperty
  a_oe: assert property (p_oe) else $error("byte undriven");
  property p_own; rxcmd_sent_q |-> $past(dir_q); endproperty
  a_own: assert property (p_own) else $error("byte unowned");
  property p_off; !sync_mode [*4] |-> !rxcmd_sent_q; endproperty
  a_off: assert property (p_off) else $error("byte off mode");
  property p_nxt; nxt_q |-> dir_q && data_oe_q && !rxcmd_sent_q; endproperty
  a_nxt: assert property (p_nxt) else $error("strobe clash");
  property p_ls; s_trig($changed(dp_rx)) |-> ##[1:6] rxcmd_sent_q; endproperty
  a_ls: assert property (p_ls) else $error("line unsent");
  property p_st; s_trig(startup_done) |-> ##[1:6] rxcmd_sent_q; endproperty
  a_st: assert property (p_st) else $error("start unsent");
  property p_ex; s_trig(mode_exit) |-> ##[1:6] rxcmd_sent_q; endproperty
  a_ex: assert property (p_ex) else $error("exit unsent");
  property p_hold; (tx_active && !stp) [*4] |-> !rxcmd_sent_q; endproperty
  a_hold: assert property (p_hold) else $error("byte in hold");
endmodule // urxcg_checker
bind urxcg_core urxcg_checker i_urxcg_checker (.clk(clk), .reset(reset), .sync_mode(sync_mode),
  .link_busy(link_busy), .tx_active(tx_active), .stp(stp), .startup_done(startup_done), .mode_exit(mode_exit),
  .dp_rx(dp_rx), .dir_q(dir_q), .nxt_q(nxt_q), .data_oe_q(data_oe_q), .rxcmd_sent_q(rxcmd_sent_q));
`default_nettype wire

//--- sim/urxcg_link_model.sv
// Purpose: Link side: stop, bus hold, byte capture
// Assumes: Bench decides when the link stops
// Notes: Never drives data, so no contention
`timescale 1ns/10ps
`default_nettype none
module urxcg_link_model (
  input wire logic       clk,          // clock
  input wire logic       stop_req,     // stop ask
  input wire logic       busy_req,     // hold ask
  input wire logic       rxcmd_sent_q, // byte
  input wire logic [7:0] data_out_q,   // bus
  output wire logic      stp,          // stop
  output wire logic      link_busy     // hold
);
  logic [7:0] got[$];
  assign stp = stop_req;
  assign link_busy = busy_req;
  always @(posedge clk) begin
    if (rxcmd_sent_q) got.push_back(data_out_q);
  end
endmodule // urxcg_link_model
`default_nettype wire

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the byte generator
// Assumes: 25 MHz clock; status packed in st
// Notes: Expected command bytes come from exp_b; received data bytes from exp_nb
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'h0, reset = 1'h1, sync_mode = 1'h1, startup_done = 1'h0, mode_exit = 1'h0, tx_active = 1'h0;
  logic rx_active = 1'h0, rx_error = 1'h0, rx_nxt = 1'h0, stop_req = 1'h0, busy_req = 1'h0, exp_nx = 1'h0;
  logic [7:0] st = 8'h00, rx_byte = 8'h00, exp_nb = 8'h00;
  wire dir_q, nxt_q, data_oe_q, rxcmd_sent_q, stp, link_busy;
  wire [7:0] data_out_q;
  int err_total = 0, checks = 0, n;
  always #20 clk = ~clk;
  urxcg_core i_urxcg_core (.clk(clk), .reset(reset), .sync_mode(sync_mode), .startup_done(startup_done),
    .mode_exit(mode_exit), .stp(stp), .link_busy(link_busy), .tx_active(tx_active), .rx_active(rx_active),
    .rx_error(rx_error), .rx_nxt(rx_nxt), .rx_byte(rx_byte), .host_disconnect_flag(st[7]), .dp_rx(st[0]),
    .dm_rx(st[1]), .session_end_flag(st[2]), .session_valid_flag(st[3]), .vbus_valid_flag(st[4]), .id_pin(st[5]),
    .alt_int(st[6]), .dir_q(dir_q), .nxt_q(nxt_q), .data_out_q(data_out_q), .data_oe_q(data_oe_q),
    .rxcmd_sent_q(rxcmd_sent_q));
  urxcg_link_model i_urxcg_link_model (.clk(clk), .stop_req(stop_req), .busy_req(busy_req),
    .rxcmd_sent_q(rxcmd_sent_q), .data_out_q(data_out_q), .stp(stp), .link_busy(link_busy));
  function automatic logic [7:0] exp_b();
    logic [1:0] v;
    v = st[4] ? 2'h3 : st[3] ? 2'h2 : st[2] ? 2'h0 : 2'h1;
    return {st[6:5], rx_active ? {rx_error, 1'h1} : {st[7], 1'h0}, v, st[1:0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_b(input logic want);
    n = i_urxcg_link_model.got.size();
    repeat (10) @(posedge clk);
    chk({7'h00, i_urxcg_link_model.got.size() > n}, {7'h00, want});
  endtask
  task automatic conclude();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h77E4DF2D));
    repeat (11) @(posedge clk);
    @(negedge clk);
    chk({4'h0, dir_q, nxt_q, data_oe_q, rxcmd_sent_q} | data_out_q, 8'h00);
    @(posedge clk);
    reset <= 1'h0;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      st <= i[0] ? {st[7:6], ~st[5], st[4:0]} : {7'($urandom()), ~st[0]};
      wait_b(1'h1);
      chk(i_urxcg_link_model.got[$], exp_b());
    end
    $display("test status done");
    for (int k = 0; k < 2; k++) begin
      sync_mode <= k[0];
      busy_req <= k[0];
      st[1] <= ~st[1];
      wait_b(1'h0);
      sync_mode <= 1'h1;
      busy_req <= 1'h0;
      wait_b(1'h1);
    end
    $display("test blocked done");
    tx_active <= 1'h1;
    @(posedge clk);
    st[0] <= ~st[0];
    wait_b(1'h0);
    stop_req <= 1'h1;
    @(posedge clk);
    stop_req <= 1'h0;
    tx_active <= 1'h0;
    wait_b(1'h1);
    startup_done <= 1'h1;
    @(posedge clk);
    startup_done <= 1'h0;
    wait_b(1'h1);
    mode_exit <= 1'h1;
    @(posedge clk);
    mode_exit <= 1'h0;
    wait_b(1'h1);
    $display("test events done");
    st[7] <= 1'h0;
    {rx_error, rx_active} <= {1'($urandom()), 1'h1};
    for (int j = 0; j < 24; j++) begin
      @(posedge clk);
      exp_nb = rx_byte;
      exp_nx = rx_nxt;
      rx_nxt <= 1'($urandom());
      rx_byte <= 8'($urandom());
      @(negedge clk);
      if (j >= 2) begin
        chk({4'h0, dir_q, data_oe_q, nxt_q, rxcmd_sent_q}, {4'h0, 1'h1, 1'h1, exp_nx, !exp_nx});
        chk(data_out_q, exp_nx ? exp_nb : exp_b());
      end
    end
    @(posedge clk);
    rx_active <= 1'h0;
    rx_nxt <= 1'h0;
    wait_b(1'h1);
    chk(i_urxcg_link_model.got[$], exp_b());
    $display("test receive done");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
